/* File: rtl/sdrcd_decoder.sv */
// SDRAM command decoder: command decode, bank state, bursts, masks, refresh.
// What this block does
// - Chip select high: no new command, ongoing bursts keep running.
// - Select low with all strobes high is a no-op; activity continues.
// - Strobes LHH activate, HLH read, HLL write, HHL burst terminate.
// - Strobes LHL precharge, LLH refresh, LLL mode register load.
// - Refresh with clock enable high is auto refresh, low is self refresh.
// - Mode load takes opcode from address bits 0..11; bit 12 should be low.
// - Activate picks bank from bank_select and opens row from bits 0..12.
// - Row stays open until precharged; controller precharges before new row.
// - Read/write: bank select, column bits 0..9, bit 10 requests auto precharge.
// - Read mask high floats that byte two clocks later; low drives data.
// - Write mask applies with the data; high means the byte is not written.
// - Precharge bit 10 low closes the named bank; high closes all banks.
// - Auto precharge closes the bank after the burst's last beat, not when terminated or cut; never on full page.
// - Burst terminate truncates the most recent read or write burst.
// - Auto refresh uses the internal counter; address inputs are ignored.
// - First read data appears the programmed latency, two or three, after read.
`timescale 1ns/1ps
module sdrcd_decoder (
    input wire logic clock, // 125 MHz system clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire sdrcd_pkg::sdrcd_pins_t pins_in, // Command pins from the controller
    output sdrcd_pkg::sdrcd_cmd_t cmd_out, // Last decoded command
    output logic cmd_valid, // Registered command strobe
    output logic [sdrcd_pkg::BANKS-1:0] bank_open, // Per-bank open flags
    output logic [sdrcd_pkg::BANKS*sdrcd_pkg::ROW_W-1:0] bank_row, // Per-bank open rows
    output logic [sdrcd_pkg::MODE_W-1:0] mode_word, // Current mode register
    output logic [sdrcd_pkg::REF_CNT_W-1:0] refresh_row, // Internal refresh row
    output logic refresh_stb, // One pulse per auto refresh
    output logic self_refresh, // Self refresh engaged
    output logic rd_active, // Read burst in progress
    output logic wr_active, // Write burst in progress
    output logic [sdrcd_pkg::BANK_W-1:0] burst_bank, // Bank of current burst
    output logic [sdrcd_pkg::COL_W-1:0] burst_col, // Current column of burst
    output logic [sdrcd_pkg::MASK_W-1:0] dq_oe_b, // Read byte drive, low drives
    output logic wr_stb, // Write beat strobe
    output logic [sdrcd_pkg::MASK_W-1:0] wr_byte_en, // Bytes written this beat
    output logic [sdrcd_pkg::COL_W-1:0] wr_col, // Column of the write beat
    output logic [sdrcd_pkg::BANK_W-1:0] wr_bank // Bank of the write beat
);
    sdrcd_pkg::sdrcd_pins_t p1_q, p_q;
    sdrcd_pkg::sdrcd_state_t s_q, s_d;
    sdrcd_pkg::sdrcd_cmd_t cmd_d, cmd_q;
    logic valid_d, valid_q;

    // Burst length in beats from the mode register, seven meaning full page
    function automatic logic [sdrcd_pkg::BURST_CNT_W-1:0] beats(input logic [sdrcd_pkg::BL_W-1:0] bl);
        unique case (bl)
            3'h0: beats = 11'h001;
            3'h1: beats = 11'h002;
            3'h2: beats = 11'h004;
            3'h3: beats = 11'h008;
            3'h7: beats = 11'h400;
            default: beats = 11'h001;
        endcase
    endfunction

    // Next column inside the wrap block for the current burst length
    function automatic logic [sdrcd_pkg::COL_W-1:0] next_col(input logic [sdrcd_pkg::COL_W-1:0] c,
                                                             input logic [sdrcd_pkg::BURST_CNT_W-1:0] n);
        logic [sdrcd_pkg::COL_W-1:0] m;
        m = (n == 11'h400) ? 10'h3FF : 10'(n - 11'h001);
        next_col = (c & ~m) | (10'(c + 10'h001) & m);
    endfunction

    // Two flip-flops on pins from the controller's domain
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            p1_q <= '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, default: '0};
            p_q <= '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, default: '0};
        end else begin
            p1_q <= pins_in;
            p_q <= p1_q;
        end
    end

    // Command decode and next-state logic
    always_comb begin
        logic [sdrcd_pkg::LAT_W-1:0] lat;
        logic [sdrcd_pkg::BURST_CNT_W-1:0] bl;
        logic wr_single;
        s_d = s_q;
        lat = s_q.mode[sdrcd_pkg::LAT_POS+:sdrcd_pkg::LAT_W];
        bl = beats(s_q.mode[sdrcd_pkg::BL_W-1:0]);
        wr_single = s_q.mode[sdrcd_pkg::WBURST_BIT];
        s_d.wr_stb = 1'b0;
        s_d.refresh_stb = 1'b0;
        s_d.rd_pipe = {s_q.rd_pipe[sdrcd_pkg::LAT_MAX-1:0], 1'b0};
        s_d.mask_pipe = {s_q.mask_pipe[sdrcd_pkg::LAT_MAX-1:0], p_q.mask};
        cmd_d = sdrcd_pkg::sdrcd_cmd_t'({p_q.ras_b, p_q.cas_b, p_q.we_b});
        valid_d = !p_q.cs_b && !s_q.self_ref;
        if (s_q.self_ref && p_q.cke) begin
            s_d.self_ref = 1'b0;
        end
        // Advance the running burst; unaffected by deselect or no-op
        if (s_q.burst != sdrcd_pkg::SDRCD_IDLE) begin
            if (s_q.burst == sdrcd_pkg::SDRCD_WRITE) begin
                s_d.wr_stb = 1'b1;
                s_d.wr_en = ~p_q.mask;
                s_d.wr_col = s_q.col;
                s_d.wr_bank = s_q.burst_bank;
            end else begin
                s_d.rd_pipe[0] = 1'b1;
            end
            s_d.col = next_col(s_q.col, bl);
            s_d.left = 11'(s_q.left - 11'h001);
            if (s_q.left == 11'h001) begin
                s_d.burst = sdrcd_pkg::SDRCD_IDLE;
                if (s_q.auto_pre) begin
                    s_d.open[s_q.burst_bank] = 1'b0;
                end
            end
        end
        if (valid_d) begin
            unique case (cmd_d)
                sdrcd_pkg::SDRCD_NOP: begin
                end
                sdrcd_pkg::SDRCD_ACT: begin
                    s_d.open[p_q.bank_select] = 1'b1;
                    s_d.row[p_q.bank_select] = p_q.addr[sdrcd_pkg::ROW_HI_BIT:0];
                end
                sdrcd_pkg::SDRCD_RD, sdrcd_pkg::SDRCD_WR: begin
                    // New access cuts any running burst
                    s_d.burst = (cmd_d == sdrcd_pkg::SDRCD_RD) ? sdrcd_pkg::SDRCD_READ
                                                               : sdrcd_pkg::SDRCD_WRITE;
                    s_d.burst_bank = p_q.bank_select;
                    s_d.col = p_q.addr[sdrcd_pkg::COL_W-1:0];
                    s_d.left = (cmd_d == sdrcd_pkg::SDRCD_WR && wr_single) ? 11'h001 : bl;
                    s_d.auto_pre = p_q.addr[sdrcd_pkg::PRE_SEL_BIT] && (bl != 11'h400);
                    if (cmd_d == sdrcd_pkg::SDRCD_WR) begin
                        // First write beat is taken with the command
                        s_d.wr_stb = 1'b1;
                        s_d.wr_en = ~p_q.mask;
                        s_d.wr_col = p_q.addr[sdrcd_pkg::COL_W-1:0];
                        s_d.wr_bank = p_q.bank_select;
                        s_d.col = next_col(p_q.addr[sdrcd_pkg::COL_W-1:0], bl);
                        s_d.left = 11'(s_d.left - 11'h001);
                        if (s_d.left == 11'h000) begin
                            s_d.burst = sdrcd_pkg::SDRCD_IDLE;
                            if (s_d.auto_pre) begin
                                s_d.open[p_q.bank_select] = 1'b0;
                            end
                        end
                    end
                end
                sdrcd_pkg::SDRCD_BST: begin
                    s_d.burst = sdrcd_pkg::SDRCD_IDLE;
                end
                sdrcd_pkg::SDRCD_PRE: begin
                    if (p_q.addr[sdrcd_pkg::PRE_SEL_BIT]) begin
                        s_d.open = '0;
                    end else begin
                        s_d.open[p_q.bank_select] = 1'b0;
                    end
                end
                sdrcd_pkg::SDRCD_REF: begin
                    s_d.ref_cnt = 13'(s_q.ref_cnt + 13'h0001);
                    if (p_q.cke) begin
                        s_d.refresh_stb = 1'b1;
                    end else begin
                        s_d.self_ref = 1'b1;
                    end
                end
                sdrcd_pkg::SDRCD_MRS: begin
                    s_d.mode = p_q.addr[sdrcd_pkg::MODE_W-1:0];
                end
            endcase
        end
        if (s_d.burst == sdrcd_pkg::SDRCD_WRITE && s_q.burst != sdrcd_pkg::SDRCD_WRITE) begin
            s_d.rd_pipe = {s_q.rd_pipe[sdrcd_pkg::LAT_MAX-1:0], 1'b0};
        end
        if (valid_d && cmd_d == sdrcd_pkg::SDRCD_RD) begin
            // Read command itself is the first beat of the data pipe
            s_d.rd_pipe[0] = 1'b1;
            s_d.col = next_col(p_q.addr[sdrcd_pkg::COL_W-1:0], bl);
            s_d.left = 11'(bl - 11'h001);
            if (bl == 11'h001) begin
                s_d.burst = sdrcd_pkg::SDRCD_IDLE;
                if (s_d.auto_pre) begin
                    s_d.open[p_q.bank_select] = 1'b0;
                end
            end
        end
        // Latency check keeps an illegal code at the slowest legal value
        if (lat != 3'(sdrcd_pkg::LAT_MIN) && lat != 3'(sdrcd_pkg::LAT_MAX)) begin
            s_d.mode[sdrcd_pkg::LAT_POS+:sdrcd_pkg::LAT_W] = 3'(sdrcd_pkg::LAT_MAX);
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{mode: sdrcd_pkg::MODE_RST, ref_cnt: sdrcd_pkg::REF_RST,
                     burst: sdrcd_pkg::SDRCD_IDLE, default: '0};
            cmd_q <= sdrcd_pkg::SDRCD_NOP;
            valid_q <= 1'b0;
        end else begin
            s_q <= s_d;
            cmd_q <= cmd_d;
            valid_q <= valid_d;
        end
    end

    // Outputs; read drive follows the latency and the mask two beats back
    always_comb begin
        logic [sdrcd_pkg::LAT_W-1:0] lat;
        lat = s_q.mode[sdrcd_pkg::LAT_POS+:sdrcd_pkg::LAT_W];
        dq_oe_b = '1;
        if (lat == 3'(sdrcd_pkg::LAT_MIN) && s_q.rd_pipe[1]) begin
            dq_oe_b = s_q.mask_pipe[1];
        end else if (lat == 3'(sdrcd_pkg::LAT_MAX) && s_q.rd_pipe[2]) begin
            dq_oe_b = s_q.mask_pipe[1];
        end
    end

    assign cmd_out = cmd_q;
    assign cmd_valid = valid_q;
    assign bank_open = s_q.open;
    assign bank_row = s_q.row;
    assign mode_word = s_q.mode;
    assign refresh_row = s_q.ref_cnt;
    assign refresh_stb = s_q.refresh_stb;
    assign self_refresh = s_q.self_ref;
    assign rd_active = (s_q.burst == sdrcd_pkg::SDRCD_READ);
    assign wr_active = (s_q.burst == sdrcd_pkg::SDRCD_WRITE);
    assign burst_bank = s_q.burst_bank;
    assign burst_col = s_q.col;
    assign wr_stb = s_q.wr_stb;
    assign wr_byte_en = s_q.wr_en;
    assign wr_col = s_q.wr_col;
    assign wr_bank = s_q.wr_bank;
endmodule

/* File: rtl/sdrcd_pkg.sv */
// Package for the SDRAM command decoder: widths, command codes and shared types.
package sdrcd_pkg;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int ADDR_W = 13;
    localparam int MODE_W = 12;
    localparam int MASK_W = 9;
    localparam int DATA_W = 72;
    localparam int REF_CNT_W = 13;
    localparam int PRE_SEL_BIT = 10;
    localparam int ROW_HI_BIT = 12;
    localparam int LAT_MIN = 2;
    localparam int LAT_MAX = 3;
    localparam int LAT_POS = 4;
    localparam int LAT_W = 3;
    localparam int BL_W = 3;
    localparam int WBURST_BIT = 9;
    localparam int BURST_CNT_W = 11;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [MODE_W-1:0] MODE_RST = 12'h030;
    localparam logic [REF_CNT_W-1:0] REF_RST = 13'h0000;

    // Strobe pattern {row, column, write}, active low
    typedef enum logic [2:0] {
        SDRCD_MRS = 3'b000,
        SDRCD_REF = 3'b001,
        SDRCD_PRE = 3'b010,
        SDRCD_ACT = 3'b011,
        SDRCD_WR = 3'b100,
        SDRCD_RD = 3'b101,
        SDRCD_BST = 3'b110,
        SDRCD_NOP = 3'b111
    } sdrcd_cmd_t;

    typedef enum logic [1:0] {
        SDRCD_IDLE = 2'b00,
        SDRCD_READ = 2'b01,
        SDRCD_WRITE = 2'b10
    } sdrcd_burst_t;

    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic cke;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
    } sdrcd_pins_t;

    typedef struct packed {
        logic [BANKS-1:0] open;
        logic [BANKS-1:0][ROW_W-1:0] row;
        logic [MODE_W-1:0] mode;
        logic [REF_CNT_W-1:0] ref_cnt;
        logic self_ref;
        sdrcd_burst_t burst;
        logic [BANK_W-1:0] burst_bank;
        logic [COL_W-1:0] col;
        logic [BURST_CNT_W-1:0] left;
        logic auto_pre;
        logic [LAT_MAX:0] rd_pipe;
        logic [LAT_MAX:0][MASK_W-1:0] mask_pipe;
        logic wr_stb;
        logic [MASK_W-1:0] wr_en;
        logic [COL_W-1:0] wr_col;
        logic [BANK_W-1:0] wr_bank;
        logic refresh_stb;
    } sdrcd_state_t;
endpackage

/* File: test/sdrcd_monitor.sv */
// Port checker for the SDRAM command decoder.
`timescale 1ns/1ps
module sdrcd_monitor (
    input wire logic clock, // System clock
    input wire logic rst_b, // Reset, active low
    input wire sdrcd_pkg::sdrcd_pins_t pins_in, // Command pins
    input wire sdrcd_pkg::sdrcd_cmd_t cmd_out, // Decoded command
    input wire logic cmd_valid, // Command strobe
    input wire logic [3:0] bank_open, // Open flags
    input wire logic [51:0] bank_row, // Open rows
    input wire logic [11:0] mode_word, // Mode register
    input wire logic [12:0] refresh_row, // Refresh counter
    input wire logic refresh_stb, // Refresh pulse
    input wire logic self_refresh, // Self refresh level
    input wire logic rd_active, // Read burst busy
    input wire logic wr_active, // Write burst busy
    input wire logic wr_stb, // Write beat
    input wire logic [8:0] wr_byte_en // Written bytes
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // A command of one kind taken this cycle
    sequence s_taken(sdrcd_pkg::sdrcd_cmd_t c);
        cmd_valid && cmd_out == c;
    endsequence
    // Decode timing and bank, mode, refresh, mask and burst stop effects
    a_deselect_idle: assert property (pins_in.cs_b |-> ##3 !cmd_valid)
        else $error("command taken while deselected");
    a_cmd_decode: assert property (!pins_in.cs_b && !self_refresh |-> ##3 cmd_valid &&
        cmd_out == $past({pins_in.ras_b, pins_in.cas_b, pins_in.we_b}, 3)) else $error("wrong command decode");
    a_act_open: assert property (s_taken(sdrcd_pkg::SDRCD_ACT) |-> bank_open[$past(pins_in.bank_select, 3)] &&
        bank_row[$past(pins_in.bank_select, 3)*13 +: 13] == $past(pins_in.addr, 3)) else $error("row not opened");
    a_mode_load: assert property (s_taken(sdrcd_pkg::SDRCD_MRS) |-> mode_word == $past(pins_in.addr[11:0], 3))
        else $error("mode word not loaded");
    a_pre_bank: assert property (s_taken(sdrcd_pkg::SDRCD_PRE) ##0 !$past(pins_in.addr[10], 3)
        |-> !bank_open[$past(pins_in.bank_select, 3)]) else $error("bank not closed");
    a_pre_all: assert property (s_taken(sdrcd_pkg::SDRCD_PRE) ##0 $past(pins_in.addr[10], 3) |-> bank_open == 4'h0)
        else $error("banks not all closed");
    a_auto_ref: assert property (s_taken(sdrcd_pkg::SDRCD_REF) ##0 $past(pins_in.cke, 3) |-> refresh_stb &&
        refresh_row == $past(refresh_row) + 13'h0001) else $error("auto refresh missed");
    a_self_ref: assert property (s_taken(sdrcd_pkg::SDRCD_REF) ##0 !$past(pins_in.cke, 3) |-> ##[0:1] self_refresh)
        else $error("self refresh not entered");
    a_write_mask: assert property (wr_stb |-> wr_byte_en == ~$past(pins_in.mask, 3))
        else $error("write mask misapplied");
    a_burst_stop: assert property (s_taken(sdrcd_pkg::SDRCD_BST) |-> ##1 !rd_active && !wr_active)
        else $error("burst not terminated");
endmodule
bind sdrcd_decoder sdrcd_monitor mon (.clock(clock), .rst_b(rst_b), .pins_in(pins_in), .cmd_out(cmd_out),
    .cmd_valid(cmd_valid), .bank_open(bank_open), .bank_row(bank_row), .mode_word(mode_word),
    .refresh_row(refresh_row), .refresh_stb(refresh_stb), .self_refresh(self_refresh), .rd_active(rd_active),
    .wr_active(wr_active), .wr_stb(wr_stb), .wr_byte_en(wr_byte_en));

/* File: test/sdrcd_ctrl_model.sv */
// Memory controller model driving the decoder command pins.
`timescale 1ns/1ps
module sdrcd_ctrl_model (
    output sdrcd_pkg::sdrcd_pins_t pins, // Command pins
    input wire logic clock // System clock
);
    // Deselected at time zero
    initial pins = 29'h1F000000;
    // One command for one cycle; mode load keeps A12 low, cke driven from the ke argument
    task automatic issue(input sdrcd_pkg::sdrcd_cmd_t c, input logic [1:0] ba, input logic [12:0] a,
        input logic [8:0] m, input logic ke);
        @(negedge clock);
        pins = '{1'b0, c[2], c[1], c[0], ke, ba, (c == sdrcd_pkg::SDRCD_MRS) ? {1'b0, a[11:0]} : a, m};
    endtask
    // Deselect; unused lines toggle so a stale value never looks valid
    task automatic gap(input int n);
        repeat (n) begin
            @(negedge clock);
            pins = '{1'b1, ~pins.ras_b, ~pins.cas_b, ~pins.we_b, pins.cke, ~pins.bank_select, ~pins.addr, ~pins.mask};
        end
    endtask
endmodule

/* File: test/tb_sdrcd_command_decoder.sv */
// Self-checking bench for the SDRAM command decoder.
`timescale 1ns/1ps
module tb_sdrcd_command_decoder;
    localparam sdrcd_pkg::sdrcd_cmd_t ACT = sdrcd_pkg::SDRCD_ACT;
    localparam sdrcd_pkg::sdrcd_cmd_t RD = sdrcd_pkg::SDRCD_RD;
    localparam sdrcd_pkg::sdrcd_cmd_t WR = sdrcd_pkg::SDRCD_WR;
    localparam sdrcd_pkg::sdrcd_cmd_t PRE = sdrcd_pkg::SDRCD_PRE;
    localparam sdrcd_pkg::sdrcd_cmd_t REF = sdrcd_pkg::SDRCD_REF;
    localparam sdrcd_pkg::sdrcd_cmd_t MRS = sdrcd_pkg::SDRCD_MRS;
    localparam sdrcd_pkg::sdrcd_cmd_t NOP = sdrcd_pkg::SDRCD_NOP;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    sdrcd_pkg::sdrcd_pins_t pins;
    sdrcd_pkg::sdrcd_cmd_t cmd_out;
    logic cmd_valid, refresh_stb, self_refresh, rd_active, wr_active, wr_stb;
    logic [3:0] bank_open;
    logic [51:0] bank_row;
    logic [11:0] mode_word;
    logic [12:0] refresh_row, r;
    logic [1:0] burst_bank, wr_bank;
    logic [9:0] burst_col, wr_col;
    logic [8:0] dq_oe_b, wr_byte_en;
    sdrcd_ctrl_model ctl (.clock(clock), .pins(pins));
    sdrcd_decoder dut (.clock(clock), .rst_b(rst_b), .pins_in(pins), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
        .bank_open(bank_open), .bank_row(bank_row), .mode_word(mode_word), .refresh_row(refresh_row),
        .refresh_stb(refresh_stb), .self_refresh(self_refresh), .rd_active(rd_active), .wr_active(wr_active),
        .burst_bank(burst_bank), .burst_col(burst_col), .dq_oe_b(dq_oe_b), .wr_stb(wr_stb),
        .wr_byte_en(wr_byte_en), .wr_col(wr_col), .wr_bank(wr_bank));
    // Clock and hang guard
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    // Land just after the edge that follows the one where a command issued last shows its effect
    task automatic after3();
        ctl.gap(3);
        step();
    endtask
    task automatic t_reset();
        check(mode_word, 12'h030);
        check(bank_open, 4'h0);
        check(dq_oe_b, 9'h1FF);
        $display("test reset done");
    endtask
    task automatic t_banks();
        for (int b = 0; b < 4; b++) ctl.issue(ACT, b[1:0], 13'h1A00 + 13'(b), 9'h000, 1'b1);
        after3();
        check(bank_open, 4'hF);
        for (int b = 0; b < 4; b++) check(bank_row[b*13 +: 13], 13'h1A00 + 13'(b));
        after3();
        check(bank_open, 4'hF);
        ctl.issue(PRE, 2'h1, 13'h0000, 9'h000, 1'b1);
        after3();
        check(bank_open, 4'hD);
        ctl.issue(PRE, 2'h1, 13'h0400, 9'h000, 1'b1);
        after3();
        check(bank_open, 4'h0);
        $display("test banks done");
    endtask
    task automatic t_write();
        ctl.issue(MRS, 2'h0, 13'h1021, 9'h000, 1'b1);
        after3();
        check(mode_word, 12'h021);
        ctl.issue(ACT, 2'h2, 13'h0055, 9'h000, 1'b1);
        ctl.gap(2);
        ctl.issue(WR, 2'h2, 13'h0405, 9'h000, 1'b1);
        ctl.issue(NOP, 2'h0, 13'h0000, 9'h1FF, 1'b1);
        ctl.gap(1);
        step();
        check({wr_stb, wr_byte_en, wr_col, wr_bank}, {1'b1, 9'h1FF, 10'h005, 2'h2});
        check(bank_open, 4'h4);
        step();
        check({wr_stb, wr_byte_en, wr_col}, {1'b1, 9'h000, 10'h004});
        step();
        step();
        check(bank_open, 4'h0);
        ctl.gap(3);
        $display("test write done");
    endtask
    task automatic t_read();
        ctl.issue(ACT, 2'h0, 13'h0100, 9'h000, 1'b1);
        ctl.gap(2);
        ctl.issue(RD, 2'h0, 13'h0002, 9'h0F0, 1'b1);
        ctl.issue(NOP, 2'h0, 13'h0000, 9'h10F, 1'b1);
        ctl.gap(1);
        step();
        check({rd_active, dq_oe_b}, {1'b1, 9'h1FF});
        check({burst_bank, burst_col}, {2'h0, 10'h003});
        step();
        check(dq_oe_b, 9'h0F0);
        step();
        check(dq_oe_b, 9'h10F);
        check(bank_open, 4'h1);
        $display("test read done");
    endtask
    task automatic t_stop();
        ctl.issue(PRE, 2'h0, 13'h0400, 9'h000, 1'b1);
        ctl.gap(2);
        ctl.issue(MRS, 2'h0, 13'h0033, 9'h000, 1'b1);
        ctl.gap(2);
        ctl.issue(ACT, 2'h3, 13'h0007, 9'h000, 1'b1);
        ctl.gap(2);
        ctl.issue(WR, 2'h3, 13'h0000, 9'h000, 1'b1);
        ctl.issue(NOP, 2'h0, 13'h0000, 9'h000, 1'b1);
        ctl.issue(sdrcd_pkg::SDRCD_BST, 2'h0, 13'h0000, 9'h000, 1'b1);
        ctl.gap(1);
        step();
        check(wr_active, 1'b1);
        step();
        step();
        check({wr_active, bank_open}, {1'b0, 4'h8});
        $display("test burst stop done");
    endtask
    task automatic t_refresh();
        r = refresh_row;
        ctl.issue(REF, 2'h3, 13'h1ABC, 9'h000, 1'b1);
        ctl.gap(2);
        step();
        check({refresh_stb, refresh_row}, {1'b1, r + 13'h0001});
        ctl.issue(REF, 2'h0, 13'h0000, 9'h000, 1'b0);
        after3();
        step();
        check(self_refresh, 1'b1);
        ctl.issue(ACT, 2'h1, 13'h0AAA, 9'h000, 1'b0);
        after3();
        check(bank_open, 4'h8);
        ctl.issue(NOP, 2'h0, 13'h0000, 9'h000, 1'b1);
        ctl.gap(5);
        step();
        check(self_refresh, 1'b0);
        $display("test refresh done");
    endtask
    // Latency three read, then a reset in the middle of its burst
    task automatic t_rerun();
        ctl.issue(RD, 2'h3, 13'h0000, 9'h1FF, 1'b1);
        ctl.issue(NOP, 2'h0, 13'h0000, 9'h0F0, 1'b1);
        ctl.gap(1);
        step();
        step();
        check({rd_active, dq_oe_b}, {1'b1, 9'h1FF});
        step();
        check(dq_oe_b, 9'h0F0);
        @(negedge clock);
        rst_b = 1'b0;
        ctl.gap(2);
        rst_b = 1'b1;
        check({rd_active, bank_open, mode_word, refresh_row}, {1'b0, 4'h0, 12'h030, 13'h0000});
        check({self_refresh, wr_stb, dq_oe_b}, {1'b0, 1'b0, 9'h1FF});
        ctl.issue(ACT, 2'h2, 13'h0123, 9'h000, 1'b1);
        after3();
        check({bank_open, bank_row[26 +: 13]}, {4'h4, 13'h0123});
        $display("test reset rerun done");
    endtask
    task automatic wrap_up();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        t_reset();
        t_banks();
        t_write();
        t_read();
        t_stop();
        t_refresh();
        t_rerun();
        wrap_up();
    end
endmodule
